/* include/jbs_pkg.sv */
// jbs_pkg: constants and state type for the test port block.
// assumes a single system clock; the test clock is sampled as data.
package jbs_pkg;
  localparam int IR_WIDTH = 3;
  localparam logic [2:0] IR_CAPTURE_PATTERN = 3'h4;
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_SAMPLE = 3'h1;
  localparam logic [2:0] IR_IDCODE = 3'h2;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam int BSR_LENGTH = 99;
  localparam int HZ6_POS = 87;
  localparam int RC6_POS = 88;
  localparam int CH6_RX_POSITIVE_DATA_OUT_POS = 86;
  localparam int CH6_RX_NEGATIVE_DATA_OUT_POS = 85;
  localparam int IDCODE_WIDTH = 32;
  localparam int RESET_TMS_EDGES = 5;

  typedef enum logic [3:0] {
    JBS_RESET = 4'h0, JBS_IDLE = 4'h1, JBS_SEL_DR = 4'h3, JBS_CAP_DR = 4'h2,
    JBS_SHIFT_DR = 4'h6, JBS_EXIT1_DR = 4'h7, JBS_PAUSE_DR = 4'h5, JBS_EXIT2_DR = 4'h4,
    JBS_UPD_DR = 4'hc, JBS_SEL_IR = 4'hd, JBS_CAP_IR = 4'hf, JBS_SHIFT_IR = 4'he,
    JBS_EXIT1_IR = 4'ha, JBS_PAUSE_IR = 4'hb, JBS_EXIT2_IR = 4'h9, JBS_UPD_IR = 4'h8
  } jbs_state_type;
endpackage : jbs_pkg

/* design/jbs_sync.sv */
// jbs_sync: two-flop synchroniser plus edge detect on the second stage.
// assumes the input is asynchronous to clk.
`timescale 1ns/1ns
module jbs_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta;
  logic stable;
  logic prev;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      stable <= meta;
      prev <= stable;
    end
  end
  assign level = stable;
  assign rise = stable & ~prev;
  assign fall = ~stable & prev;
endmodule : jbs_sync

/* design/jbs_tap.sv */
// jbs_tap: test access port controller with instruction, bypass, id and boundary scan.
// assumes tck, tms, tdi come from a pin; tck is far slower than clk.
// Notes on behaviour
// RULE1: cell 87 at 0 enables channel 6 outputs
// RULE2: cell 87 at 1 floats channel 6 outputs
// RULE3: sixteen-state machine, steps on tck rise
// RULE4: reset state: normal mode, load idcode
// RULE5: five tms-high edges always reach reset
// RULE6: power-up reset lands in reset state
// RULE7: idle holds on low, high to select-dr
// RULE8: select-dr: low capture, high select-ir
// RULE9: capture-dr loads pins for extest/sample
// RULE10: capture-dr: high exit1, low shift
// RULE11: shift-dr moves data toward tdo
// RULE12: exit1-dr: high update, low pause
// RULE13: transient states keep instruction and data
// RULE14: pause-dr holds, exit2-dr to update/shift
// RULE15: update-dr latches boundary outputs on fall
// RULE16: capture-ir loads pattern 100
// RULE17: update-ir latches instruction on fall
// RULE18: update states: low idle, high select-dr
`timescale 1ns/1ns
module jbs_tap #(
  parameter int BSR_LEN = jbs_pkg::BSR_LENGTH,
  parameter logic [31:0] ID_VALUE = 32'h00000001 // arbitrary neutral code
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [BSR_LEN-1:0] pin_levels,
  input wire logic ch6_core_positive_data,
  input wire logic ch6_core_negative_data,
  input wire logic ch6_core_recovered_clock,
  output logic ch6_rx_positive_data_out,
  output logic ch6_rx_negative_data_out,
  output logic ch6_rx_recovered_clock_out,
  output logic ch6_rx_output_oe,
  output logic test_mode,
  output jbs_pkg::jbs_state_type tap_state
);
  // chain must reach past the channel 6 cells
  if (BSR_LEN <= jbs_pkg::RC6_POS) begin : g_bad_length
    $error("boundary chain too short");
  end

  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;
  logic tck_s;

  jbs_sync u_tck (.clk(clk), .resetn(resetn), .pin(tck), .level(tck_s),
    .rise(tck_rise), .fall(tck_fall));
  jbs_sync u_tms (.clk(clk), .resetn(resetn), .pin(tms), .level(tms_s),
    .rise(), .fall());
  jbs_sync u_tdi (.clk(clk), .resetn(resetn), .pin(tdi), .level(tdi_s),
    .rise(), .fall());

  jbs_pkg::jbs_state_type state;
  jbs_pkg::jbs_state_type next_state;
  logic [2:0] ir_shift;
  logic [2:0] next_ir_shift;
  logic [2:0] ir;
  logic [2:0] next_ir;
  logic [BSR_LEN-1:0] bsr_shift;
  logic [BSR_LEN-1:0] next_bsr_shift;
  logic [BSR_LEN-1:0] bsr_out;
  logic [BSR_LEN-1:0] next_bsr_out;
  logic [31:0] id_shift;
  logic [31:0] next_id_shift;
  logic bypass;
  logic next_bypass;
  logic tdo_q;
  logic next_tdo_q;
  logic tdo_en;
  logic next_tdo_en;

  function automatic logic bsr_selected(input logic [2:0] instr);
    return (instr == jbs_pkg::IR_EXTEST) || (instr == jbs_pkg::IR_SAMPLE);
  endfunction : bsr_selected

  always_comb begin
    next_state = state;
    if (tck_rise) begin
      case (state) // RULE3
        jbs_pkg::JBS_RESET: // RULE5
          next_state = tms_s ? jbs_pkg::JBS_RESET : jbs_pkg::JBS_IDLE;
        jbs_pkg::JBS_IDLE: // RULE7
          next_state = tms_s ? jbs_pkg::JBS_SEL_DR : jbs_pkg::JBS_IDLE;
        jbs_pkg::JBS_SEL_DR: // RULE8
          next_state = tms_s ? jbs_pkg::JBS_SEL_IR : jbs_pkg::JBS_CAP_DR;
        jbs_pkg::JBS_CAP_DR: // RULE10
          next_state = tms_s ? jbs_pkg::JBS_EXIT1_DR : jbs_pkg::JBS_SHIFT_DR;
        jbs_pkg::JBS_SHIFT_DR: // RULE11
          next_state = tms_s ? jbs_pkg::JBS_EXIT1_DR : jbs_pkg::JBS_SHIFT_DR;
        jbs_pkg::JBS_EXIT1_DR: // RULE12
          next_state = tms_s ? jbs_pkg::JBS_UPD_DR : jbs_pkg::JBS_PAUSE_DR;
        jbs_pkg::JBS_PAUSE_DR: // RULE14
          next_state = tms_s ? jbs_pkg::JBS_EXIT2_DR : jbs_pkg::JBS_PAUSE_DR;
        jbs_pkg::JBS_EXIT2_DR: // RULE14
          next_state = tms_s ? jbs_pkg::JBS_UPD_DR : jbs_pkg::JBS_SHIFT_DR;
        jbs_pkg::JBS_UPD_DR: // RULE18
          next_state = tms_s ? jbs_pkg::JBS_SEL_DR : jbs_pkg::JBS_IDLE;
        jbs_pkg::JBS_SEL_IR: // RULE5
          next_state = tms_s ? jbs_pkg::JBS_RESET : jbs_pkg::JBS_CAP_IR;
        jbs_pkg::JBS_CAP_IR: next_state = tms_s ? jbs_pkg::JBS_EXIT1_IR : jbs_pkg::JBS_SHIFT_IR;
        jbs_pkg::JBS_SHIFT_IR: next_state = tms_s ? jbs_pkg::JBS_EXIT1_IR : jbs_pkg::JBS_SHIFT_IR;
        jbs_pkg::JBS_EXIT1_IR: next_state = tms_s ? jbs_pkg::JBS_UPD_IR : jbs_pkg::JBS_PAUSE_IR;
        jbs_pkg::JBS_PAUSE_IR: next_state = tms_s ? jbs_pkg::JBS_EXIT2_IR : jbs_pkg::JBS_PAUSE_IR;
        jbs_pkg::JBS_EXIT2_IR: next_state = tms_s ? jbs_pkg::JBS_UPD_IR : jbs_pkg::JBS_SHIFT_IR;
        jbs_pkg::JBS_UPD_IR: next_state = tms_s ? jbs_pkg::JBS_SEL_DR : jbs_pkg::JBS_IDLE; // RULE18
        default: next_state = jbs_pkg::JBS_RESET;
      endcase
    end
  end

  // registers change only in reset, capture, shift and update, except tdo_q and tdo_en, which load on every tck fall in any state
  always_comb begin
    next_ir_shift = ir_shift;
    next_ir = ir;
    next_bsr_shift = bsr_shift;
    next_bsr_out = bsr_out;
    next_id_shift = id_shift;
    next_bypass = bypass;
    next_tdo_q = tdo_q;
    next_tdo_en = tdo_en;
    if (state == jbs_pkg::JBS_RESET) begin
      next_ir = jbs_pkg::IR_IDCODE; // RULE4
    end
    if (tck_rise) begin // RULE13
      case (state)
        jbs_pkg::JBS_CAP_DR: begin
          if (bsr_selected(ir)) next_bsr_shift = pin_levels; // RULE9
          next_id_shift = ID_VALUE;
          next_bypass = 1'b0;
        end
        jbs_pkg::JBS_SHIFT_DR: begin // RULE11
          if (bsr_selected(ir)) next_bsr_shift = {tdi_s, bsr_shift[BSR_LEN-1:1]};
          else if (ir == jbs_pkg::IR_IDCODE) next_id_shift = {tdi_s, id_shift[31:1]};
          else next_bypass = tdi_s;
        end
        jbs_pkg::JBS_CAP_IR: next_ir_shift = jbs_pkg::IR_CAPTURE_PATTERN; // RULE16
        jbs_pkg::JBS_SHIFT_IR: next_ir_shift = {tdi_s, ir_shift[2:1]};
        default: begin
        end
      endcase
    end
    if (tck_fall) begin
      next_tdo_en = (state == jbs_pkg::JBS_SHIFT_DR) || (state == jbs_pkg::JBS_SHIFT_IR);
      if (state == jbs_pkg::JBS_SHIFT_IR) next_tdo_q = ir_shift[0];
      else if (bsr_selected(ir)) next_tdo_q = bsr_shift[0];
      else if (ir == jbs_pkg::IR_IDCODE) next_tdo_q = id_shift[0];
      else next_tdo_q = bypass;
      if (state == jbs_pkg::JBS_UPD_DR && bsr_selected(ir)) next_bsr_out = bsr_shift; // RULE15
      if (state == jbs_pkg::JBS_UPD_IR) next_ir = ir_shift; // RULE17
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= jbs_pkg::JBS_RESET; // RULE6
      ir_shift <= 3'h0;
      ir <= jbs_pkg::IR_IDCODE;
      bsr_shift <= '0;
      bsr_out <= '0;
      id_shift <= 32'h0;
      bypass <= 1'b0;
      tdo_q <= 1'b0;
      tdo_en <= 1'b0;
    end else begin
      state <= next_state;
      ir_shift <= next_ir_shift;
      ir <= next_ir;
      bsr_shift <= next_bsr_shift;
      bsr_out <= next_bsr_out;
      id_shift <= next_id_shift;
      bypass <= next_bypass;
      tdo_q <= next_tdo_q;
      tdo_en <= next_tdo_en;
    end
  end

  // only extest drives pins from the chain; otherwise core owns them
  assign test_mode = (ir == jbs_pkg::IR_EXTEST);
  assign tap_state = state;
  assign tdo = tdo_q;
  assign tdo_oe = tdo_en;
  assign ch6_rx_positive_data_out = test_mode ? bsr_out[jbs_pkg::CH6_RX_POSITIVE_DATA_OUT_POS]
                                              : ch6_core_positive_data;
  assign ch6_rx_negative_data_out = test_mode ? bsr_out[jbs_pkg::CH6_RX_NEGATIVE_DATA_OUT_POS]
                                              : ch6_core_negative_data;
  assign ch6_rx_recovered_clock_out = test_mode ? bsr_out[jbs_pkg::RC6_POS]
                                                : ch6_core_recovered_clock;
  // ch6_rx_output_tristate_cell: 0 drives, 1 floats
  assign ch6_rx_output_oe = test_mode ? ~bsr_out[jbs_pkg::HZ6_POS] : 1'b1; // RULE1 RULE2

  // saturating count of tck rises with tms high, feeds the reset check only
  logic [2:0] tms_high_count;
  logic [2:0] next_tms_high_count;
  always_comb begin
    next_tms_high_count = tms_high_count;
    if (tck_rise && !tms_s) begin
      next_tms_high_count = 3'h0;
    end else if (tck_rise && tms_high_count != 3'(jbs_pkg::RESET_TMS_EDGES)) begin
      next_tms_high_count = tms_high_count + 3'h1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tms_high_count <= 3'h0;
    end else begin
      tms_high_count <= next_tms_high_count;
    end
  end

  property p_five_tms_reset;
    @(posedge clk) disable iff (!resetn)
      (tms_high_count == 3'(jbs_pkg::RESET_TMS_EDGES)) |-> state == jbs_pkg::JBS_RESET;
  endproperty
  a_five_tms_reset: assert property (p_five_tms_reset) else $error("no reset after 5 tms"); // RULE5

  property p_idle_hold;
    @(posedge clk) disable iff (!resetn)
      (state == jbs_pkg::JBS_IDLE && tck_rise && !tms_s) |=> state == jbs_pkg::JBS_IDLE;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle left with tms low"); // RULE7

  property p_sel_dr;
    @(posedge clk) disable iff (!resetn) (state == jbs_pkg::JBS_SEL_DR && tck_rise)
      |=> state == ($past(tms_s) ? jbs_pkg::JBS_SEL_IR : jbs_pkg::JBS_CAP_DR);
  endproperty
  a_sel_dr: assert property (p_sel_dr) else $error("bad select-dr step"); // RULE8

  property p_cap_ir;
    @(posedge clk) disable iff (!resetn)
      (state == jbs_pkg::JBS_CAP_IR && tck_rise) |=> ir_shift == jbs_pkg::IR_CAPTURE_PATTERN;
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("capture-ir pattern wrong"); // RULE16

  property p_ir_stable;
    @(posedge clk) disable iff (!resetn)
      (state != jbs_pkg::JBS_UPD_IR && state != jbs_pkg::JBS_RESET) |=> $stable(ir);
  endproperty
  a_ir_stable: assert property (p_ir_stable) else $error("instruction changed"); // RULE13

  property p_bsr_out;
    @(posedge clk) disable iff (!resetn)
      !(state == jbs_pkg::JBS_UPD_DR && tck_fall) |=> $stable(bsr_out);
  endproperty
  a_bsr_out: assert property (p_bsr_out) else $error("boundary output moved"); // RULE15

  property p_hz6;
    @(posedge clk) disable iff (!resetn)
      test_mode |-> ch6_rx_output_oe == !bsr_out[jbs_pkg::HZ6_POS];
  endproperty
  a_hz6: assert property (p_hz6) else $error("channel 6 enable wrong"); // RULE1

  property p_reset_ir;
    @(posedge clk) disable iff (!resetn)
      state == jbs_pkg::JBS_RESET |=> ir == jbs_pkg::IR_IDCODE;
  endproperty
  a_reset_ir: assert property (p_reset_ir) else $error("reset did not load idcode"); // RULE4
endmodule : jbs_tap

/* testbench/jbs_tester.sv */
// jbs_tester: board tester model driving the scan port's test pins.
// assumes clk is the bench clock; tck stands low between steps.
`timescale 1ns/1ns
module jbs_tester (
  input wire logic clk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
  end

  // one 160 ns tck period; tdo taken just before the rise, once settled
  task automatic step(input logic t, input logic d, output logic b);
    @(posedge clk);
    tms <= t;
    tdi <= d;
    repeat (7) @(posedge clk);
    b = tdo;
    tck <= 1'b1;
    repeat (8) @(posedge clk);
    tck <= 1'b0;
    // tdi hold is over: show the inverse, not the old value
    tdi <= ~d;
  endtask : step
endmodule : jbs_tester

/* testbench/jtag_tap_and_boundary_scan_test.sv */
// jtag_tap_and_boundary_scan_test: self-checking bench for the test port block.
// assumes the tester model supplies tck at 160 ns against a 100 MHz clk.
`timescale 1ns/1ns
module jtag_tap_and_boundary_scan_test;
  localparam logic [31:0] ID = 32'h00000001; // arbitrary neutral code
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [98:0] pins = 99'h5a5a5a5a5c3c3c3c30f0f0f0f;
  logic tck, tms, tdi, tdo, toe, rdp, rdn, rc, oe, tm;
  jbs_pkg::jbs_state_type st;
  int fails = 0;
  int compares = 0;
  logic [30:0] wt = 31'h7696af25;
  jbs_pkg::jbs_state_type ws [0:30] = '{jbs_pkg::JBS_SEL_DR, jbs_pkg::JBS_CAP_DR,
    jbs_pkg::JBS_EXIT1_DR, jbs_pkg::JBS_PAUSE_DR, jbs_pkg::JBS_PAUSE_DR, jbs_pkg::JBS_EXIT2_DR,
    jbs_pkg::JBS_SHIFT_DR, jbs_pkg::JBS_SHIFT_DR, jbs_pkg::JBS_EXIT1_DR, jbs_pkg::JBS_UPD_DR,
    jbs_pkg::JBS_SEL_DR, jbs_pkg::JBS_SEL_IR, jbs_pkg::JBS_CAP_IR, jbs_pkg::JBS_EXIT1_IR,
    jbs_pkg::JBS_PAUSE_IR, jbs_pkg::JBS_EXIT2_IR, jbs_pkg::JBS_SHIFT_IR, jbs_pkg::JBS_EXIT1_IR,
    jbs_pkg::JBS_UPD_IR, jbs_pkg::JBS_IDLE, jbs_pkg::JBS_SEL_DR, jbs_pkg::JBS_CAP_DR,
    jbs_pkg::JBS_SHIFT_DR, jbs_pkg::JBS_EXIT1_DR, jbs_pkg::JBS_PAUSE_DR, jbs_pkg::JBS_EXIT2_DR,
    jbs_pkg::JBS_UPD_DR, jbs_pkg::JBS_IDLE, jbs_pkg::JBS_SEL_DR, jbs_pkg::JBS_SEL_IR,
    jbs_pkg::JBS_RESET};

  initial begin
    forever #5 clk = ~clk;
  end

  jbs_tester i_tester (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));

  jbs_tap #(.ID_VALUE(ID)) i_dut (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(toe), .pin_levels(pins), .ch6_core_positive_data(1'b1),
    .ch6_core_negative_data(1'b0), .ch6_core_recovered_clock(1'b1),
    .ch6_rx_positive_data_out(rdp), .ch6_rx_negative_data_out(rdn),
    .ch6_rx_recovered_clock_out(rc), .ch6_rx_output_oe(oe), .test_mode(tm), .tap_state(st));

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_state(input jbs_pkg::jbs_state_type got, input jbs_pkg::jbs_state_type exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_state

  task automatic chk_vec(input logic [98:0] got, input logic [98:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_vec

  task automatic seq(input logic [7:0] t, input int n);
    logic b;
    for (int i = 0; i < n; i++) begin
      i_tester.step(t[i], 1'b0, b);
    end
  endtask : seq

  // shifts n bits lsb first, leaving the port in exit1
  task automatic scan(input int n, input logic [98:0] din, output logic [98:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      i_tester.step(i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask : scan

  task automatic t_reset();
    logic [98:0] d;
    chk_state(st, jbs_pkg::JBS_RESET);
    chk_bit(tm, 1'b0);
    chk_bit(oe, 1'b1);
    chk_bit(rdp, 1'b1);
    chk_bit(rdn, 1'b0);
    chk_bit(rc, 1'b1);
    chk_bit(toe, 1'b0);
    seq(8'h00, 3);
    chk_state(st, jbs_pkg::JBS_IDLE);
    seq(8'h01, 3);
    scan(32, '0, d);
    chk_vec(d, {67'h0, ID});
    seq(8'h01, 2);
    $display("reset test done");
  endtask : t_reset

  task automatic t_walk();
    logic b;
    for (int i = 0; i < 31; i++) begin
      i_tester.step(wt[i], 1'b0, b);
      chk_state(st, ws[i]);
    end
    $display("walk test done");
  endtask : t_walk

  task automatic t_tms_reset();
    seq(8'h02, 4);
    seq(8'h1f, 5);
    chk_state(st, jbs_pkg::JBS_RESET);
    seq(8'h01, 1);
    chk_state(st, jbs_pkg::JBS_RESET);
    $display("tms reset test done");
  endtask : t_tms_reset

  task automatic t_ir();
    logic [98:0] d;
    seq(8'h06, 5);
    // tdo enable follows the tck fall by a few clk
    repeat (4) @(posedge clk);
    chk_bit(toe, 1'b1);
    scan(3, '0, d);
    chk_vec(d, 99'h4);
    chk_bit(tm, 1'b0);
    seq(8'h01, 2);
    chk_bit(tm, 1'b1);
    chk_bit(toe, 1'b0);
    $display("instruction test done");
  endtask : t_ir

  task automatic t_bsr();
    logic [98:0] a, d;
    a = '0;
    a[88:85] = 4'he;
    seq(8'h01, 3);
    scan(99, a, d);
    chk_vec(d, pins);
    chk_bit(oe, 1'b1);
    seq(8'h01, 2);
    chk_bit(oe, 1'b0);
    a[88:85] = 4'h2;
    seq(8'h01, 3);
    scan(99, a, d);
    chk_vec(d, pins);
    seq(8'h01, 2);
    chk_bit(oe, 1'b1);
    chk_bit(rdp, 1'b1);
    chk_bit(rdn, 1'b0);
    chk_bit(rc, 1'b0);
    $display("boundary test done");
  endtask : t_bsr

  // sample leaves the core on the pins; bypass is a single stage
  task automatic t_modes();
    logic [98:0] d;
    seq(8'h03, 4);
    scan(3, 99'h1, d);
    chk_vec(d, 99'h4);
    seq(8'h01, 2);
    chk_bit(tm, 1'b0);
    chk_bit(rc, 1'b1);
    seq(8'h01, 3);
    scan(99, '0, d);
    chk_vec(d, pins);
    seq(8'h01, 2);
    chk_bit(oe, 1'b1);
    seq(8'h03, 4);
    scan(3, 99'h7, d);
    chk_vec(d, 99'h4);
    seq(8'h05, 5);
    scan(2, 99'h1, d);
    chk_vec(d, 99'h2);
    seq(8'h01, 2);
    chk_state(st, jbs_pkg::JBS_IDLE);
    $display("mode test done");
  endtask : t_modes

  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // hang guard well above the longest sequence
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_walk();
    t_tms_reset();
    t_ir();
    t_bsr();
    t_modes();
    stop_test();
  end
endmodule : jtag_tap_and_boundary_scan_test
